// ===== pmb_program_map.sv
// boot-mode capture and program-space map for the signal controller
// =========================================
// How it works
// - secured, pin low: internal, 16 lines, locked
// - secured, pin high: force both bits 00
// - unsecured, pin low: internal boot, 16 lines
// - unsecured, pin high: external boot, width pin
// - security bit loaded at reset, then takes software writes
// - security bit write changes no map
// - boot-source bit writable, 0 internal 1 external
// - secured at reset: boot-source write ignored
// - chip selects start as program/data strobes
// - external boot, width pin high: GPIO become A19..A16
// - internal map: flash, ext RAM, boot flash
// - external narrow: ext RAM low, flash relocated
// - external wide: boot from external 0x020000
module pmb_program_map (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // pins and flash state
  input wire logic externalBootPin,
  input wire logic extMemWidthPin,
  input wire logic flashSecured,
  // operating mode register writes
  input wire logic bootSourceWrite,
  input wire logic bootSourceData,
  input wire logic securityWrite,
  input wire logic securityData,
  // program fetch decode
  input wire logic [20:0] fetchAddr,
  output pmb_pkg::pmb_target_t fetchTarget,
  output logic [20:0] fetchLocalAddr,
  // mode bits and configuration
  output logic bootSourceModeBit,
  output logic securityModeBit,
  output logic configValid,
  output logic externalBootMode,
  output logic wideAddressBus,
  output logic [4:0] extAddrLines,
  output logic extProgramAllowed,
  output logic debugUnitEnable,
  // chip select and pin roles
  output logic legacyStrobeMode,
  output logic gpioAsHighAddr,
  // boot vectors
  output logic [20:0] bootAddress,
  output logic [20:0] watchdogResetAddress
);
  // =========================================
  // pin synchronisation
  logic [1:0] pinSync;
  pmb_sync #(.WIDTH(2)) pinSyncInst (
    .core_clk(core_clk),
    .resetn(resetn),
    .pinIn({externalBootPin, extMemWidthPin}),
    .pinOut(pinSync)
  );
  wire logic bootPinS = pinSync[1];
  wire logic widthPinS = pinSync[0];

  // =========================================
  // reset capture sequence
  // sample three cycles after release so the synchroniser holds true pin levels
  pmb_pkg::pmb_state_t state;
  pmb_pkg::pmb_state_t next_state;
  logic [1:0] settle;
  wire logic settleDone = (settle == 2'h2);

  always_comb begin
    case (state)
      pmb_pkg::PMB_S_RESET: next_state = settleDone ? pmb_pkg::PMB_S_SAMPLE : pmb_pkg::PMB_S_RESET;
      pmb_pkg::PMB_S_SAMPLE: next_state = pmb_pkg::PMB_S_RUN;
      pmb_pkg::PMB_S_RUN: next_state = pmb_pkg::PMB_S_RUN;
      default: next_state = pmb_pkg::PMB_S_RESET;
    endcase
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state <= pmb_pkg::PMB_S_RESET;
      settle <= 2'h0;
    end else begin
      state <= next_state;
      settle <= settleDone ? settle : settle + 2'h1;
    end
  end

  wire logic capture = (state == pmb_pkg::PMB_S_SAMPLE);

  // =========================================
  // captured mode decisions
  // secured forces the boot-source bit low
  wire logic capSecurity = !flashSecured;
  wire logic capBootSrc = bootPinS && !flashSecured;
  // width pin matters only in external boot
  wire logic capWide = capBootSrc && widthPinS;

  logic lockedSecure;
  logic widePinLatched;

  // captured once, held until next reset; only securityModeBit also takes software writes
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      securityModeBit <= pmb_pkg::RST_SECURITY;
      lockedSecure <= 1'h1;
      externalBootMode <= 1'h0;
      widePinLatched <= 1'h0;
    end else if (capture) begin
      securityModeBit <= capSecurity;
      lockedSecure <= !capSecurity;
      externalBootMode <= capBootSrc;
      widePinLatched <= capWide;
    end else if (securityWrite) begin
      // software copy only, map ignores it
      securityModeBit <= securityData;
    end
  end

  // =========================================
  // boot-source bit
  // writable after reset unless secured, steers the map
  wire logic bootSrcWriteOk = bootSourceWrite && !lockedSecure && (state == pmb_pkg::PMB_S_RUN);

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      bootSourceModeBit <= pmb_pkg::RST_BOOT_SRC;
    end else if (capture) begin
      bootSourceModeBit <= capBootSrc;
    end else if (bootSrcWriteOk) begin
      bootSourceModeBit <= bootSourceData;
    end
  end

  // =========================================
  // static configuration outputs
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      configValid <= 1'h0;
    end else begin
      configValid <= configValid || capture;
    end
  end

  // width pin high in external boot: twenty address lines
  assign wideAddressBus = widePinLatched;
  assign gpioAsHighAddr = widePinLatched;
  assign extAddrLines = widePinLatched ? 5'(pmb_pkg::EXT_ADDR_WIDE) : 5'(pmb_pkg::EXT_ADDR_NARROW);
  // secured: no external program space, no debug
  assign extProgramAllowed = !lockedSecure;
  assign debugUnitEnable = !lockedSecure;
  // legacy strobes out of reset; remapping lives elsewhere
  assign legacyStrobeMode = 1'h1;

  // =========================================
  // boot and watchdog vectors
  // internal boot at boot flash
  wire logic bootLow = externalBootMode && !widePinLatched;
  assign bootAddress = bootLow ? pmb_pkg::REGION_00_LO : pmb_pkg::REGION_02_LO;
  assign watchdogResetAddress = bootAddress + pmb_pkg::WDOG_OFFSET;

  // =========================================
  // live program map
  // high space reachable only after software pin setup, outside this block
  // region selection by live boot-source bit
  pmb_decode decodeInst (
    .extMap(bootSourceModeBit),
    .wideBus(widePinLatched),
    .extAllowed(extProgramAllowed),
    .fetchAddr(fetchAddr),
    .target(fetchTarget),
    .localAddr(fetchLocalAddr)
  );
endmodule : pmb_program_map

// ===== pmb_pkg.sv
// shared constants for program map and boot select
package pmb_pkg;
  // =========================================
  // address widths
  localparam int PADDR_W = 21;
  localparam int EXT_ADDR_NARROW = 16;
  localparam int EXT_ADDR_WIDE = 20;
  // =========================================
  // region bounds, program word addresses
  localparam logic [20:0] REGION_00_LO = 21'h000000;
  localparam logic [20:0] REGION_01_LO = 21'h010000;
  localparam logic [20:0] REGION_02_LO = 21'h020000;
  localparam logic [20:0] BOOTFL_HI = 21'h020FFF;
  localparam logic [20:0] RSVD_LO = 21'h021000;
  localparam logic [20:0] PRAM_LO = 21'h02F800;
  localparam logic [20:0] PRAM_HI = 21'h02FFFF;
  localparam logic [20:0] HIGH_EXT_LO = 21'h100000;
  localparam logic [20:0] HIGH_EXT_HI = 21'h1FFFFF;
  localparam logic [20:0] WDOG_OFFSET = 21'h000002;
  // =========================================
  // reset values of the mode bits
  localparam logic RST_BOOT_SRC = 1'h0;
  localparam logic RST_SECURITY = 1'h0;
  // =========================================
  // decoded target of a program fetch
  typedef enum logic [2:0] {
    PMB_T_NONE = 3'h0,
    PMB_T_FLASH = 3'h1,
    PMB_T_BOOTFL = 3'h3,
    PMB_T_PRAM = 3'h2,
    PMB_T_EXT = 3'h6
  } pmb_target_t;
  // =========================================
  // reset capture sequence
  typedef enum logic [1:0] {
    PMB_S_RESET = 2'h0,
    PMB_S_SAMPLE = 2'h1,
    PMB_S_RUN = 2'h3
  } pmb_state_t;
endpackage : pmb_pkg

// ===== pmb_sync.sv
// two-flop synchroniser for pin levels
module pmb_sync #(
  parameter int WIDTH = 2
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // level in and out
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] pinOut
);
  logic [WIDTH-1:0] stage1;

  // pins idle high through their pull-ups, so reset to ones
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      stage1 <= '1;
      pinOut <= '1;
    end else begin
      stage1 <= pinIn;
      pinOut <= stage1;
    end
  end
endmodule : pmb_sync

// ===== pmb_decode.sv
// program-space address decoder for the active map
module pmb_decode (
  // map selection
  input wire logic extMap,
  input wire logic wideBus,
  input wire logic extAllowed,
  // fetch address
  input wire logic [20:0] fetchAddr,
  // decoded target
  output pmb_pkg::pmb_target_t target,
  output logic [20:0] localAddr
);
  function automatic logic inRange(input logic [20:0] a, input logic [20:0] lo, input logic [20:0] hi);
    inRange = (a >= lo) && (a <= hi);
  endfunction : inRange

  wire logic inLow = inRange(fetchAddr, pmb_pkg::REGION_00_LO, pmb_pkg::REGION_01_LO - 21'h000001);
  wire logic inMid = inRange(fetchAddr, pmb_pkg::REGION_01_LO, pmb_pkg::REGION_02_LO - 21'h000001);
  wire logic inBoot = inRange(fetchAddr, pmb_pkg::REGION_02_LO, pmb_pkg::BOOTFL_HI);
  wire logic inPram = inRange(fetchAddr, pmb_pkg::PRAM_LO, pmb_pkg::PRAM_HI);
  wire logic inHigh = inRange(fetchAddr, pmb_pkg::HIGH_EXT_LO, pmb_pkg::HIGH_EXT_HI);
  wire logic external_boot_pin = extMap && wideBus;
  wire logic flashHit = extMap ? inMid : inLow;
  wire logic extLowHit = extMap ? inLow : inMid;
  wire logic bootHit = inBoot && !external_boot_pin;
  wire logic extBootHit = inBoot && external_boot_pin;
  wire logic anyExt = extLowHit || extBootHit || inHigh;

  // external regions vanish when program space is forbidden
  assign target = flashHit ? pmb_pkg::PMB_T_FLASH :
                  bootHit ? pmb_pkg::PMB_T_BOOTFL :
                  inPram ? pmb_pkg::PMB_T_PRAM :
                  (anyExt && extAllowed) ? pmb_pkg::PMB_T_EXT :
                  pmb_pkg::PMB_T_NONE;
  assign localAddr = flashHit ? (fetchAddr - (extMap ? pmb_pkg::REGION_01_LO : pmb_pkg::REGION_00_LO)) :
                     bootHit ? (fetchAddr - pmb_pkg::REGION_02_LO) :
                     inPram ? (fetchAddr - pmb_pkg::PRAM_LO) : fetchAddr;
endmodule : pmb_decode

// ===== pmb_program_map_properties.sv
// assertion checker for boot-mode capture and program map
module pmb_map_checker (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // mode writes and fetch
  input wire logic bootSourceWrite,
  input wire logic bootSourceData,
  input wire logic securityWrite,
  input wire logic securityData,
  input wire logic [20:0] fetchAddr,
  input wire pmb_pkg::pmb_target_t fetchTarget,
  // configuration outputs
  input wire logic bootSourceModeBit,
  input wire logic securityModeBit,
  input wire logic configValid,
  input wire logic externalBootMode,
  input wire logic wideAddressBus,
  input wire logic [4:0] extAddrLines,
  input wire logic extProgramAllowed,
  input wire logic debugUnitEnable,
  input wire logic legacyStrobeMode,
  input wire logic [20:0] bootAddress,
  input wire logic [20:0] watchdogResetAddress
);
  default clocking dc @(posedge core_clk);
  endclocking
  default disable iff (!resetn);
  // =========================================
  // capture sequence
  sequence s_release;
    $rose(resetn);
  endsequence
  sequence s_settle;
    !configValid [*4] ##1 configValid;
  endsequence
  a_capture_timing: assert property (s_release |-> s_settle)
    else $error("configuration late or early after release");
  a_config_hold: assert property (configValid && $past(configValid) |-> $stable(externalBootMode)
    && $stable(wideAddressBus) && $stable(bootAddress) && $stable(extProgramAllowed))
    else $error("captured configuration moved");
  a_secure_lock: assert property (configValid && !extProgramAllowed |-> !externalBootMode
    && !wideAddressBus && !debugUnitEnable && !bootSourceModeBit)
    else $error("secured part not locked to internal boot");
  a_lines_width: assert property (extAddrLines == (wideAddressBus ? 5'h14 : 5'h10))
    else $error("address line count disagrees with width");
  a_boot_vector: assert property (configValid |-> bootAddress ==
    ((externalBootMode && !wideAddressBus) ? 21'h000000 : 21'h020000))
    else $error("boot address wrong for mode");
  a_wdog_vector: assert property (watchdogResetAddress == bootAddress + 21'h000002)
    else $error("watchdog vector not boot plus two");
  a_legacy_strobe: assert property (legacyStrobeMode)
    else $error("chip selects not in strobe mode");
  a_boot_write: assert property (configValid && extProgramAllowed && bootSourceWrite
    |=> bootSourceModeBit == $past(bootSourceData))
    else $error("boot-source write not taken");
  a_locked_write: assert property (configValid && !extProgramAllowed |=> $stable(bootSourceModeBit))
    else $error("boot-source bit moved while secured");
  a_sec_write: assert property (configValid && securityWrite
    |=> securityModeBit == $past(securityData) && $stable(bootAddress))
    else $error("security write mishandled");
  a_sec_stable: assert property (configValid && !securityWrite |=> $stable(securityModeBit))
    else $error("security bit moved without write");
  a_flash_low: assert property (!bootSourceModeBit && fetchAddr[20:16] == 5'h00
    |-> fetchTarget == pmb_pkg::PMB_T_FLASH)
    else $error("low page not flash in internal map");
endmodule : pmb_map_checker
bind pmb_program_map pmb_map_checker chk (.*);

// ===== pmb_ext_mem.sv
// external program memory model on the fetch side
module pmb_ext_mem (
  // clock
  input wire logic core_clk,
  // fetch request
  input wire logic select,
  input wire logic highReady,
  input wire logic [20:0] addr,
  // read data
  output logic [15:0] rdData
);
  timeunit 1ns;
  timeprecision 1ps;
  // high space dead until pins set
  wire answer = select && (!addr[20] || highReady);
  always_ff @(posedge core_clk) begin
    // released bus must not show a stale word
    rdData <= answer ? (addr[15:0] ^ 16'hA5A5) : ~rdData;
  end
endmodule : pmb_ext_mem

// ===== tb_pmb_program_map.sv
// self-checking bench for boot-mode capture and program map
module tb_pmb_program_map;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic sec, eb, wm, ext, wide, ok; logic [20:0] boot;} pmb_row_t;
  logic core_clk = 1'h0, resetn = 1'h0, externalBootPin = 1'h0, extMemWidthPin = 1'h0, flashSecured = 1'h0;
  logic bootSourceWrite = 1'h0, bootSourceData = 1'h0, securityWrite = 1'h0, securityData = 1'h0;
  logic highReady = 1'h1;
  logic [20:0] fetchAddr = 21'h000000;
  logic [20:0] fetchLocalAddr, bootAddress, watchdogResetAddress;
  logic bootSourceModeBit, securityModeBit, configValid, externalBootMode, wideAddressBus;
  logic extProgramAllowed, debugUnitEnable, legacyStrobeMode, gpioAsHighAddr;
  logic [4:0] extAddrLines;
  logic [15:0] memData;
  pmb_pkg::pmb_target_t fetchTarget;
  int n_fail = 0;
  int comparisons = 0;
  // secured, boot pin, width pin / external, wide, allowed / boot address
  pmb_row_t rows [8] = '{{3'h4, 3'h0, 21'h020000}, {3'h6, 3'h0, 21'h020000}, {3'h7, 3'h0, 21'h020000},
    {3'h5, 3'h0, 21'h020000}, {3'h0, 3'h1, 21'h020000}, {3'h1, 3'h1, 21'h020000},
    {3'h2, 3'h5, 21'h000000}, {3'h3, 3'h7, 21'h020000}};
  pmb_program_map dut (.*);
  pmb_ext_mem mem (.core_clk, .select(fetchTarget == pmb_pkg::PMB_T_EXT), .highReady, .addr(fetchLocalAddr),
    .rdData(memData));
  // =========================================
  // helpers
  task automatic chk(input logic [20:0] seen, input logic [20:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk
  task automatic give_verdict();
    $display("comparisons %0d, n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : give_verdict
  task automatic boot(input logic [2:0] pins);
    int i;
    @(posedge core_clk);
    resetn <= 1'h0;
    {flashSecured, externalBootPin, extMemWidthPin} <= pins;
    repeat (16) @(posedge core_clk);
    chk(configValid, 1'h0);
    resetn <= 1'h1;
    for (i = 0; i < 20 && configValid !== 1'h1; i++) begin
      @(posedge core_clk);
      #1;
    end
    if (i == 20) begin
      n_fail++;
      give_verdict();
    end
  endtask : boot
  task automatic fetch(input logic [20:0] a);
    @(posedge core_clk);
    fetchAddr <= a;
    #1;
  endtask : fetch
  task automatic write_mode(input logic src, input logic d);
    @(posedge core_clk);
    if (src)
      {bootSourceWrite, bootSourceData} <= {1'h1, d};
    else
      {securityWrite, securityData} <= {1'h1, d};
    @(posedge core_clk);
    {bootSourceWrite, securityWrite} <= 2'h0;
    #1;
  endtask : write_mode
  // =========================================
  // stimulus
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    pmb_row_t r;
    foreach (rows[k]) begin
      r = rows[k];
      boot({r.sec, r.eb, r.wm});
      chk(externalBootMode, r.ext);
      chk(bootSourceModeBit, r.ext);
      chk(wideAddressBus, r.wide);
      chk(gpioAsHighAddr, r.wide);
      chk(extAddrLines, r.wide ? 5'h14 : 5'h10);
      chk(extProgramAllowed, r.ok);
      chk(debugUnitEnable, r.ok);
      chk(securityModeBit, r.ok);
      chk(legacyStrobeMode, 1'h1);
      chk(bootAddress, r.boot);
      chk(watchdogResetAddress, r.boot + 21'h000002);
      fetch(21'h000000);
      chk(fetchTarget, r.ext ? pmb_pkg::PMB_T_EXT : pmb_pkg::PMB_T_FLASH);
      fetch(21'h010000);
      chk(fetchTarget, r.ext ? pmb_pkg::PMB_T_FLASH : r.ok ? pmb_pkg::PMB_T_EXT : pmb_pkg::PMB_T_NONE);
      chk(fetchLocalAddr, r.ext ? 21'h000000 : 21'h010000);
      fetch(21'h020000);
      chk(fetchTarget, r.wide ? pmb_pkg::PMB_T_EXT : pmb_pkg::PMB_T_BOOTFL);
      chk(fetchLocalAddr, r.wide ? 21'h020000 : 21'h000000);
      $display("row %0d done", k);
    end
    boot(3'h1);
    write_mode(1'h1, 1'h1);
    chk(bootSourceModeBit, 1'h1);
    fetch(21'h000000);
    chk(fetchTarget, pmb_pkg::PMB_T_EXT);
    write_mode(1'h1, 1'h0);
    fetch(21'h010000);
    chk(fetchTarget, pmb_pkg::PMB_T_EXT);
    @(posedge core_clk);
    flashSecured <= 1'h1;
    repeat (3) @(posedge core_clk);
    #1;
    chk(securityModeBit, 1'h1);
    write_mode(1'h0, 1'h0);
    chk(securityModeBit, 1'h0);
    chk(fetchTarget, pmb_pkg::PMB_T_EXT);
    $display("mode writes done");
    boot(3'h4);
    write_mode(1'h1, 1'h1);
    chk(bootSourceModeBit, 1'h0);
    fetch(21'h000000);
    chk(fetchTarget, pmb_pkg::PMB_T_FLASH);
    $display("secured write done");
    boot(3'h3);
    fetch(21'h100000);
    chk(fetchTarget, pmb_pkg::PMB_T_EXT);
    @(posedge core_clk);
    #1;
    chk(memData, 16'hA5A5);
    // high space goes dead when the pins are not set up
    highReady <= 1'h0;
    @(posedge core_clk);
    #1;
    chk(memData, 16'h5A5A);
    fetch(21'h02F800);
    chk(fetchTarget, pmb_pkg::PMB_T_PRAM);
    chk(fetchLocalAddr, 21'h000000);
    $display("high external fetch done");
    give_verdict();
  end
endmodule : tb_pmb_program_map
